// ---- hw/slms_defines.svh ----
// Offsets, field positions, reset values and limits of the loop mode selector.
// Assumes inclusion by the design module, the assertion checker and the testbench.
`ifndef SLMS_DEFINES_SVH
`define SLMS_DEFINES_SVH

`define SLMS_ADDR_SWITCH_CTRL   4'h0
`define SLMS_ADDR_TORQUE_THR    4'h1
`define SLMS_ADDR_SPEED_THR     4'h2
`define SLMS_ADDR_ACCEL_THR     4'h3
`define SLMS_ADDR_DEV_THR       4'h4
`define SLMS_ADDR_PRED_CTRL     4'h5
`define SLMS_ADDR_PRED_GAIN     4'h6
`define SLMS_ADDR_PRED_WEIGHT   4'h7
`define SLMS_ADDR_STATUS        4'h8
`define SLMS_ADDR_PRED_LOADED   4'h9

`define SLMS_PRED_EN_BIT        0
`define SLMS_PRED_TYPE_BIT      1

`define SLMS_TORQUE_THR_MAX     16'h0320
`define SLMS_SPEED_THR_MAX      16'h2710
`define SLMS_ACCEL_THR_MAX      16'h7530
`define SLMS_DEV_THR_MAX        16'h2710
`define SLMS_PCT_MAX            16'h012C

`define SLMS_TORQUE_THR_RST     16'h00C8
`define SLMS_COND_RST           2'h0
`define SLMS_PRED_GAIN_RST      16'h0064
`define SLMS_PRED_WEIGHT_RST    16'h0064

`endif

// ---- hw/slms_pkg.sv ----
// Types of the servo loop mode selector.
// Assumes the defines header is on the include path.
package slms_pkg;
    typedef enum logic [1:0] {
        SLMS_COND_TORQUE = 2'h0,
        SLMS_COND_SPEED  = 2'h1,
        SLMS_COND_ACCEL  = 2'h2,
        SLMS_COND_DEV    = 2'h3
    } slms_cond_e;

    typedef enum logic [2:0] {
        SLMS_ST_IDLE = 3'b001,
        SLMS_ST_CALC = 3'b010,
        SLMS_ST_RUN  = 3'b100
    } slms_pred_state_e;
endpackage

// ---- hw/slms_selector.sv ----
// Speed loop PI/P mode selector with predictive control settings.
// Assumes quantities arrive as magnitudes on clk, refreshed every control cycle.
// Overview of operation
// - The speed loop drops to P-only control when the chosen quantity reaches its threshold.
// - A two-bit selector picks torque, speed, acceleration or deviation, each with a threshold.
// - Torque mode uses P-only while torque command is at or above a 0..800 percent threshold.
// - After reset the selector is torque mode and the torque threshold is 200 percent.
// - Speed mode uses P-only while speed command is at or above a 0..10000 r/min threshold.
// - Acceleration mode uses P-only while acceleration is at or above a 0..30000 threshold.
// - Deviation mode uses P-only while deviation is at or above a 0..10000 unit threshold.
// - Predictive control is active only when enabled and in position control mode.
// - A type setting chooses positioning prediction or tracking prediction.
// - On enable, predictive parameters are computed from the position loop gain then in use.
// - The predictive acceleration gain takes 0..300 percent and scales that term.
// - The predictive weighting ratio takes 0..300 percent and weights the deviation.
// - Type value 0 means tracking prediction and 1 means positioning prediction.
// - Predictive selection changes take effect only after a power cycle.
`timescale 1ns/10ps
`include "slms_defines.svh"

module slms_selector
    import slms_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic              ctrl_cycle,
    input  wire logic              position_mode,
    input  wire logic [DATA_W-1:0] torque_cmd,
    input  wire logic [DATA_W-1:0] speed_cmd,
    input  wire logic [DATA_W-1:0] accel_value,
    input  wire logic [DATA_W-1:0] position_deviation,
    input  wire logic [15:0]       position_loop_gain,
    output logic                   p_only_r,
    output logic                   predictive_active_r,
    output logic                   predictive_positioning_r,
    output logic      [15:0]       predictive_accel_term_r,
    output logic      [15:0]       predictive_weight_term_r
);

    initial begin
        if (DATA_W < 16 || DATA_W > 32) begin
            $error("slms_selector: DATA_W must be 16 to 32");
        end
    end

    // Clamp a written value to its documented maximum
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
        clamp16 = (v > mx) ? mx : v;
    endfunction

    // Percent scaling of a 16-bit quantity, saturating
    function automatic logic [15:0] pct_scale(input logic [15:0] v, input logic [15:0] pct);
        logic [31:0] prod;
        logic [31:0] q;
        prod = 32'(v) * 32'(pct);
        q    = prod / 32'h0000_0064;
        pct_scale = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
    endfunction

    slms_cond_e       p_switch_condition_select_r;
    logic [15:0]      p_switch_torque_threshold_r;
    logic [15:0]      p_switch_speed_threshold_r;
    logic [15:0]      p_switch_accel_threshold_r;
    logic [15:0]      p_switch_deviation_threshold_r;
    // Survives rst_b, which stands for the power cycle that puts it into effect
    logic [1:0]       pred_ctrl_pending_r = 2'h0;
    logic             predictive_enable_r;
    logic             predictive_type_select_r;
    logic [15:0]      predictive_accel_gain_r;
    logic [15:0]      predictive_weight_ratio_r;
    logic [15:0]      kp_loaded_r;
    slms_pred_state_e pred_state_r;
    slms_pred_state_e pred_state_nxt;
    logic             pred_loaded_r;
    logic             p_only_nxt;
    logic [DATA_W-1:0] quantity;
    logic [DATA_W-1:0] threshold;

    // Switching condition settings
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p_switch_condition_select_r    <= SLMS_COND_TORQUE;
            p_switch_torque_threshold_r    <= `SLMS_TORQUE_THR_RST;
            p_switch_speed_threshold_r     <= 16'h0000;
            p_switch_accel_threshold_r     <= 16'h0000;
            p_switch_deviation_threshold_r <= 16'h0000;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `SLMS_ADDR_SWITCH_CTRL: begin
                    p_switch_condition_select_r <= slms_cond_e'(reg_wdata[1:0]);
                end
                `SLMS_ADDR_TORQUE_THR: begin
                    p_switch_torque_threshold_r <= clamp16(reg_wdata, `SLMS_TORQUE_THR_MAX);
                end
                `SLMS_ADDR_SPEED_THR: begin
                    p_switch_speed_threshold_r <= clamp16(reg_wdata, `SLMS_SPEED_THR_MAX);
                end
                `SLMS_ADDR_ACCEL_THR: begin
                    p_switch_accel_threshold_r <= clamp16(reg_wdata, `SLMS_ACCEL_THR_MAX);
                end
                `SLMS_ADDR_DEV_THR: begin
                    p_switch_deviation_threshold_r <= clamp16(reg_wdata, `SLMS_DEV_THR_MAX);
                end
                default: begin
                end
            endcase
        end
    end

    // Staged predictive selection, kept across rst_b so it can act after it
    always_ff @(posedge clk) begin
        if (clk_en && reg_wr && reg_addr == `SLMS_ADDR_PRED_CTRL) begin
            pred_ctrl_pending_r <= reg_wdata[1:0];
        end
    end

    // Predictive tuning percentages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            predictive_accel_gain_r   <= `SLMS_PRED_GAIN_RST;
            predictive_weight_ratio_r <= `SLMS_PRED_WEIGHT_RST;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `SLMS_ADDR_PRED_GAIN: begin
                    predictive_accel_gain_r <= clamp16(reg_wdata, `SLMS_PCT_MAX);
                end
                `SLMS_ADDR_PRED_WEIGHT: begin
                    predictive_weight_ratio_r <= clamp16(reg_wdata, `SLMS_PCT_MAX);
                end
                default: begin
                end
            endcase
        end
    end

    // Selection copied into effect once, at the first enabled edge after reset
    logic boot_done_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_done_r              <= 1'b0;
            predictive_enable_r      <= 1'b0;
            predictive_type_select_r <= 1'b0;
        end else if (clk_en && !boot_done_r) begin
            boot_done_r              <= 1'b1;
            predictive_enable_r      <= pred_ctrl_pending_r[`SLMS_PRED_EN_BIT];
            predictive_type_select_r <= pred_ctrl_pending_r[`SLMS_PRED_TYPE_BIT];
        end
    end

    // Quantity and threshold selection
    always_comb begin
        case (p_switch_condition_select_r)
            SLMS_COND_TORQUE: begin
                quantity  = torque_cmd;
                threshold = DATA_W'(p_switch_torque_threshold_r);
            end
            SLMS_COND_SPEED: begin
                quantity  = speed_cmd;
                threshold = DATA_W'(p_switch_speed_threshold_r);
            end
            SLMS_COND_ACCEL: begin
                quantity  = accel_value;
                threshold = DATA_W'(p_switch_accel_threshold_r);
            end
            SLMS_COND_DEV: begin
                quantity  = position_deviation;
                threshold = DATA_W'(p_switch_deviation_threshold_r);
            end
            default: begin
                quantity  = torque_cmd;
                threshold = DATA_W'(p_switch_torque_threshold_r);
            end
        endcase
        p_only_nxt = (quantity >= threshold);
    end

    // PI/P decision, refreshed each control cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p_only_r <= 1'b0;
        end else if (clk_en && ctrl_cycle) begin
            p_only_r <= p_only_nxt;
        end
    end

    // Predictive sequencer: capture gain on enable, then run
    always_comb begin
        case (pred_state_r)
            SLMS_ST_IDLE: begin
                pred_state_nxt = (predictive_enable_r && position_mode) ?
                                 SLMS_ST_CALC : SLMS_ST_IDLE;
            end
            SLMS_ST_CALC: begin
                pred_state_nxt = SLMS_ST_RUN;
            end
            SLMS_ST_RUN: begin
                pred_state_nxt = (predictive_enable_r && position_mode) ?
                                 SLMS_ST_RUN : SLMS_ST_IDLE;
            end
            default: begin
                pred_state_nxt = SLMS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pred_state_r <= SLMS_ST_IDLE;
        end else if (clk_en) begin
            pred_state_r <= pred_state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kp_loaded_r   <= 16'h0000;
            pred_loaded_r <= 1'b0;
        end else if (clk_en && pred_state_r == SLMS_ST_IDLE && pred_state_nxt == SLMS_ST_CALC) begin
            kp_loaded_r   <= position_loop_gain;
            pred_loaded_r <= 1'b1;
        end
    end

    // Predictive outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            predictive_active_r      <= 1'b0;
            predictive_positioning_r <= 1'b0;
            predictive_accel_term_r  <= 16'h0000;
            predictive_weight_term_r <= 16'h0000;
        end else if (clk_en) begin
            predictive_active_r      <= (pred_state_nxt == SLMS_ST_RUN);
            predictive_positioning_r <= predictive_type_select_r;
            if (pred_state_nxt == SLMS_ST_RUN) begin
                predictive_accel_term_r  <= pct_scale(kp_loaded_r, predictive_accel_gain_r);
                predictive_weight_term_r <= pct_scale(kp_loaded_r, predictive_weight_ratio_r);
            end else begin
                predictive_accel_term_r  <= 16'h0000;
                predictive_weight_term_r <= 16'h0000;
            end
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    `SLMS_ADDR_SWITCH_CTRL: reg_rdata <= {14'h0000, p_switch_condition_select_r};
                    `SLMS_ADDR_TORQUE_THR:  reg_rdata <= p_switch_torque_threshold_r;
                    `SLMS_ADDR_SPEED_THR:   reg_rdata <= p_switch_speed_threshold_r;
                    `SLMS_ADDR_ACCEL_THR:   reg_rdata <= p_switch_accel_threshold_r;
                    `SLMS_ADDR_DEV_THR:     reg_rdata <= p_switch_deviation_threshold_r;
                    `SLMS_ADDR_PRED_CTRL:   reg_rdata <= {14'h0000, pred_ctrl_pending_r};
                    `SLMS_ADDR_PRED_GAIN:   reg_rdata <= predictive_accel_gain_r;
                    `SLMS_ADDR_PRED_WEIGHT: reg_rdata <= predictive_weight_ratio_r;
                    `SLMS_ADDR_STATUS: begin
                        reg_rdata <= {12'h000, pred_loaded_r, predictive_type_select_r,
                                      predictive_active_r, p_only_r};
                    end
                    `SLMS_ADDR_PRED_LOADED: reg_rdata <= kp_loaded_r;
                    default:                reg_rdata <= 16'h0000;
                endcase
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

endmodule

// ---- testbench/slms_sel_assertions.sv ----
// Port checker for the loop mode selector, with shadow copies of mode and thresholds.
// Assumes it is bound into slms_selector and sees only that module's ports.
`timescale 1ns/10ps
`include "slms_defines.svh"

module slms_sel_checker #(
    parameter int DATA_W = 16
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              clk_en,
    input wire logic [3:0]        reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic              ctrl_cycle,
    input wire logic              position_mode,
    input wire logic [DATA_W-1:0] torque_cmd,
    input wire logic [DATA_W-1:0] speed_cmd,
    input wire logic [DATA_W-1:0] accel_value,
    input wire logic [DATA_W-1:0] position_deviation,
    input wire logic              p_only_r,
    input wire logic              predictive_active_r,
    input wire logic [15:0]       predictive_accel_term_r,
    input wire logic [15:0]       predictive_weight_term_r
);
    logic [1:0]        cond_r;
    logic [15:0]       thr_r [4];
    logic [15:0]       lim;
    logic [15:0]       rd_exp;
    logic [DATA_W-1:0] qty;
    logic              hit;

    assign lim = (reg_addr == 4'h1) ? `SLMS_TORQUE_THR_MAX :
                 (reg_addr == 4'h3) ? `SLMS_ACCEL_THR_MAX : `SLMS_SPEED_THR_MAX;
    assign qty = (cond_r == 2'h0) ? torque_cmd : (cond_r == 2'h1) ? speed_cmd :
                 (cond_r == 2'h2) ? accel_value : position_deviation;
    assign hit = qty >= DATA_W'(thr_r[cond_r]);
    assign rd_exp = (reg_addr == 4'h0) ? {14'h0000, cond_r} : thr_r[2'(reg_addr - 4'h1)];

    // Over-range threshold writes land clamped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cond_r <= `SLMS_COND_RST;
            thr_r <= '{`SLMS_TORQUE_THR_RST, 16'h0000, 16'h0000, 16'h0000};
        end else if (clk_en && reg_wr && reg_addr == 4'h0) begin
            cond_r <= reg_wdata[1:0];
        end else if (clk_en && reg_wr && reg_addr >= 4'h1 && reg_addr <= 4'h4) begin
            thr_r[2'(reg_addr - 4'h1)] <= (reg_wdata > lim) ? lim : reg_wdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_DECIDE: assert property (clk_en && ctrl_cycle |=> p_only_r == $past(hit))
        else $error("speed loop mode differs from threshold compare");
    AST_HOLD: assert property (!(clk_en && ctrl_cycle) |=> $stable(p_only_r))
        else $error("speed loop mode moved between ticks");
    AST_TORQUE: assert property (clk_en && ctrl_cycle && cond_r == 2'h0
        && torque_cmd >= DATA_W'(thr_r[0]) |=> p_only_r) else $error("torque mode missed");
    AST_RELEASE: assert property (clk_en && ctrl_cycle && !hit |=> !p_only_r)
        else $error("integral action not restored");
    AST_READBACK: assert property (clk_en && reg_rd && reg_addr < 4'h5
        |=> reg_rdata == $past(rd_exp)) else $error("setting read back wrong");
    AST_STATUS: assert property (clk_en && reg_rd && reg_addr == 4'h8
        |=> reg_rdata[1:0] == $past({predictive_active_r, p_only_r})) else $error("status wrong");
    AST_PRED_ZERO: assert property (!predictive_active_r |->
        predictive_accel_term_r == 16'h0000 && predictive_weight_term_r == 16'h0000)
        else $error("predictive terms while inactive");
    AST_PRED_MODE: assert property (clk_en && !position_mode |=> !predictive_active_r)
        else $error("predictive active outside position mode");

    COV_P_ON: cover property ($rose(p_only_r));
    COV_P_OFF: cover property ($fell(p_only_r));
    COV_STATUS: cover property (clk_en && reg_rd && reg_addr == 4'h8);
    COV_PRED_ON: cover property ($rose(predictive_active_r));
endmodule

bind slms_selector slms_sel_checker #(.DATA_W(DATA_W)) slms_sel_checker_inst (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_cycle(ctrl_cycle),
    .position_mode(position_mode), .torque_cmd(torque_cmd), .speed_cmd(speed_cmd),
    .accel_value(accel_value), .position_deviation(position_deviation), .p_only_r(p_only_r),
    .predictive_active_r(predictive_active_r),
    .predictive_accel_term_r(predictive_accel_term_r),
    .predictive_weight_term_r(predictive_weight_term_r)
);

// ---- testbench/slms_motor_model.sv ----
// Motor and encoder side: control-cycle tick and the four measured magnitudes.
// Assumes the bench picks which quantity carries mag; the others sit at full scale.
`timescale 1ns/10ps

module slms_motor_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  sel,
    input  wire logic [15:0] mag,
    output logic             ctrl_cycle,
    output logic      [15:0] qty [4]
);
    logic [1:0] cnt_r;

    // Tick every fourth clock; magnitudes refresh only on the tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 2'h0;
            ctrl_cycle <= 1'b0;
            qty <= '{default: 16'hFFFF};
        end else begin
            cnt_r <= cnt_r + 2'h1;
            ctrl_cycle <= (cnt_r == 2'h3);
            for (int i = 0; i < 4; i++) begin
                if (ctrl_cycle) begin
                    qty[i] <= (i == sel) ? mag : 16'hFFFF;
                end
            end
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the loop mode selector.
// Assumes the checker is bound in and the motor model feeds the quantities.
`timescale 1ns/10ps
`include "slms_defines.svh"
`define TB_CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module tb_top;
    import slms_pkg::*;
    logic        clk = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, position_mode = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [1:0]  sel = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, mag = 16'h0000, position_loop_gain = 16'h0000;
    logic [15:0] reg_rdata, acc_term, wgt_term;
    logic [15:0] qty [4];
    logic        ctrl_cycle, p_only_r, predictive_active_r, predictive_positioning_r;
    int          n_mismatch = 0, n_checks = 0;
    logic [15:0] thr_max [4] = '{`SLMS_TORQUE_THR_MAX, `SLMS_SPEED_THR_MAX,
                                 `SLMS_ACCEL_THR_MAX, `SLMS_DEV_THR_MAX};

    always #12.5 clk = ~clk;

    slms_motor_model slms_motor_model_inst (.clk(clk), .rst_b(rst_b), .sel(sel), .mag(mag),
        .ctrl_cycle(ctrl_cycle), .qty(qty));
    slms_selector slms_selector_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ctrl_cycle(ctrl_cycle), .position_mode(position_mode),
        .torque_cmd(qty[0]), .speed_cmd(qty[1]), .accel_value(qty[2]),
        .position_deviation(qty[3]), .position_loop_gain(position_loop_gain),
        .p_only_r(p_only_r), .predictive_active_r(predictive_active_r),
        .predictive_positioning_r(predictive_positioning_r),
        .predictive_accel_term_r(acc_term), .predictive_weight_term_r(wgt_term));

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // New magnitude is latched on one tick and judged on the next
    task automatic apply(input logic [15:0] v);
        @(posedge clk);
        mag <= v;
        repeat (2) @(posedge clk iff ctrl_cycle);
        #1;
    endtask

    task automatic t_reset_values();
        logic [15:0] d;
        logic [15:0] exp_v [8] = '{16'h0000, `SLMS_TORQUE_THR_RST, 16'h0000, 16'h0000,
                                   16'h0000, 16'h0000, `SLMS_PRED_GAIN_RST, 16'h0064};
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), d);
            `TB_CHECK(d, exp_v[a])
        end
        rd(4'hF, d);
        `TB_CHECK(d, 16'h0000)
    endtask

    task automatic t_modes();
        logic [15:0] d;
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, {14'h0000, 2'(m)});
            wr(4'(m + 1), thr_max[m] + 16'h0001);
            rd(4'(m + 1), d);
            `TB_CHECK(d, thr_max[m])
            sel <= 2'(m);
            apply(thr_max[m] - 16'h0001);
            `TB_CHECK(p_only_r, 1'b0)
            apply(thr_max[m]);
            `TB_CHECK(p_only_r, 1'b1)
            rd(4'h8, d);
            `TB_CHECK(d[0], 1'b1)
            apply(thr_max[m] - 16'h0001);
            `TB_CHECK(p_only_r, 1'b0)
        end
    endtask

    task automatic t_pred();
        logic [15:0] d;
        wr(4'h5, 16'h0003);
        @(posedge clk);
        position_mode <= 1'b1;
        position_loop_gain <= 16'h0200;
        repeat (8) @(posedge clk);
        #1;
        `TB_CHECK(predictive_active_r, 1'b0)
        `TB_CHECK({acc_term, wgt_term}, 32'h0000_0000)
        wr(4'h6, 16'h0190);
        rd(4'h6, d);
        `TB_CHECK(d, `SLMS_PCT_MAX)
        wr(4'h7, 16'h012D);
        rd(4'h7, d);
        `TB_CHECK(d, `SLMS_PCT_MAX)
        rd(4'h8, d);
        `TB_CHECK(d[3:1], 3'h0)
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h1, d);
        `TB_CHECK(d, `SLMS_TORQUE_THR_RST)
        rd(4'h0, d);
        `TB_CHECK(d, 16'h0000)
        `TB_CHECK(predictive_active_r, 1'b1)
        `TB_CHECK(predictive_positioning_r, 1'b1)
        `TB_CHECK(acc_term, 16'h0200)
        `TB_CHECK(wgt_term, 16'h0200)
        rd(4'h9, d);
        `TB_CHECK(d, 16'h0200)
        rd(4'h8, d);
        `TB_CHECK(d[3:1], 3'h7)
        position_mode <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `TB_CHECK(predictive_active_r, 1'b0)
        `TB_CHECK({acc_term, wgt_term}, 32'h0000_0000)
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values();
        t_modes();
        t_pred();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
